// File: rri_pkg.sv
// Constants for the module-register reset and initialization sequencer
package rri_pkg;
    // ------------------------------------------------------------
    // Widths and clock frequency
    // ------------------------------------------------------------
    localparam int CS_W = 4;
    localparam int CS_W_TWO = 2;
    localparam int ODT_W = 2;
    localparam int CKE_W = 2;
    localparam int AC_W = 24;
    localparam int YCLK_W = 4;
    localparam int CLK_HZ = 40000000;
    // ------------------------------------------------------------
    // Timing, stabilization interval (us) minus activation lead (us)
    // ------------------------------------------------------------
    localparam int STAB_US = 15;
    localparam int ACT_US = 0;
    localparam int STAB_CYC_RAW = (STAB_US - ACT_US) * (CLK_HZ / 1000000);
    localparam int STAB_CYC = (STAB_CYC_RAW < 1) ? 1 : STAB_CYC_RAW;
    localparam int CNT_W = 16;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        RRI_RESET = 4'b0001,
        RRI_WAIT_EDGE = 4'b0010,
        RRI_STAB = 4'b0100,
        RRI_RUN = 4'b1000
    } rri_state_t;
endpackage

// File: rri_seq.sv
// Reset and initialization output sequencer of a registering clock driver
//
// Operation
// RULE1: In reset, clock-enable outputs are driven low and parity error stays high.
// RULE2: In reset, all other outputs float.
// RULE3: Controller holds chip-select inputs high before releasing reset.
// RULE4: Controller keeps clock-enable inputs low through release and stabilization.
// RULE5: After release, termination outputs are low until the first clock edge.
// RULE6: After first edge, termination outputs follow inputs within stabilization time.
// RULE7: Soft reset is held at least 100 ns by the controller.
// RULE8: At power-up, reset stays asserted for at least 200 us of stable power.
// RULE9: Chip-select bus is two bits, or four in four-select mode.
// RULE10: Feedback clock may float during initialization; here it is driven.
// RULE11: After the clock-enable-low step, outputs follow normal function.
// RULE12: On release, chip-selects go high and output clocks restart.
`timescale 1ns/1ps
module rri_seq
    import rri_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Device reset pin, active low
    input wire logic reset_n,
    // Mode strap
    input wire logic four_select_mode,
    // Controller inputs
    input wire logic [rri_pkg::CS_W-1:0] chip_select_in,
    input wire logic [rri_pkg::ODT_W-1:0] termination_ctrl_in,
    input wire logic [rri_pkg::CKE_W-1:0] clock_enable_in,
    input wire logic [rri_pkg::AC_W-1:0] addr_cmd_in,
    input wire logic parity_in,
    input wire logic input_clock_rise,
    // Outputs with enables, and init_done
    output logic [rri_pkg::CS_W-1:0] chip_select_out,
    output logic [rri_pkg::CS_W-1:0] chip_select_oe,
    output logic [rri_pkg::ODT_W-1:0] termination_ctrl_out,
    output logic termination_ctrl_oe,
    output logic [rri_pkg::CKE_W-1:0] clock_enable_out,
    output logic clock_enable_oe,
    output logic [rri_pkg::AC_W-1:0] addr_cmd_out,
    output logic addr_cmd_oe,
    output logic parity_error_out,
    output logic parity_error_oe,
    output logic out_clock_run,
    output logic out_clock_oe,
    output logic feedback_clock_out,
    output logic feedback_clock_oe,
    output logic init_done
);
    import rri_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rri_state_t state;
    rri_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic par_d;
    logic next_par_d;
    logic fb_div;
    logic next_fb_div;

    logic [CS_W-1:0] next_cs;
    logic [CS_W-1:0] next_cs_oe;
    logic [ODT_W-1:0] next_odt;
    logic next_odt_oe;
    logic [CKE_W-1:0] next_cke;
    logic next_cke_oe;
    logic [AC_W-1:0] next_ac;
    logic next_ac_oe;
    logic next_err;
    logic next_err_oe;
    logic next_yrun;
    logic next_yoe;
    logic next_fb_oe;
    logic next_done;
    logic [CS_W-1:0] cs_mask;
    logic cs_one_low;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        cs_mask = four_select_mode ? {CS_W{1'b1}} : {{(CS_W-CS_W_TWO){1'b0}}, {CS_W_TWO{1'b1}}}; // [RULE9]
        cs_one_low = ($countones(~chip_select_in & cs_mask) == 1);
        next_state = state;
        next_cnt = cnt;
        next_par_d = parity_in;
        next_fb_div = fb_div;
        next_cs = chip_select_out;
        next_cs_oe = chip_select_oe;
        next_odt = termination_ctrl_out;
        next_odt_oe = termination_ctrl_oe;
        next_cke = clock_enable_out;
        next_cke_oe = 1'b1;
        next_ac = addr_cmd_out;
        next_ac_oe = addr_cmd_oe;
        next_err = 1'b1;
        next_err_oe = 1'b0;
        next_yrun = out_clock_run;
        next_yoe = out_clock_oe;
        next_fb_oe = feedback_clock_oe;
        next_done = init_done;
        if (!reset_n) begin
            next_state = RRI_RESET;
            next_cnt = '0;
            next_cke = '0; // [RULE1]
            next_err = 1'b1; // [RULE1]
            next_err_oe = 1'b0; // [RULE1]
            next_cs_oe = '0; // [RULE2]
            next_odt_oe = 1'b0; // [RULE2]
            next_ac_oe = 1'b0; // [RULE2]
            next_yrun = 1'b0; // [RULE2]
            next_yoe = 1'b0; // [RULE2]
            next_fb_oe = 1'b0; // [RULE2]
            next_done = 1'b0;
        end else begin
            case (state)
                RRI_RESET: begin
                    next_state = RRI_WAIT_EDGE;
                    next_cs = cs_mask; // [RULE12]
                    next_cs_oe = cs_mask; // [RULE12]
                    next_odt = '0; // [RULE5]
                    next_odt_oe = 1'b1; // [RULE5]
                    next_cke = '0;
                    next_ac = '0;
                    next_ac_oe = 1'b1;
                    next_yrun = 1'b1; // [RULE12]
                    next_yoe = 1'b1; // [RULE12]
                    next_fb_oe = 1'b1; // [RULE10]
                end
                RRI_WAIT_EDGE: begin
                    if (input_clock_rise) begin
                        next_state = RRI_STAB; // [RULE6]
                        next_odt = termination_ctrl_in; // [RULE6]
                        next_cnt = '0;
                    end
                end
                RRI_STAB: begin
                    // Controller keeps clock enables low here [RULE4]
                    next_odt = termination_ctrl_in; // [RULE6]
                    next_cke = '0;
                    if (cnt == CNT_W'(STAB_CYC - 1)) begin
                        next_state = RRI_RUN;
                        next_done = 1'b1;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                RRI_RUN: begin
                    if (input_clock_rise) begin
                        next_odt = termination_ctrl_in; // [RULE11]
                        next_cke = clock_enable_in; // [RULE11]
                        next_cs = chip_select_in | ~cs_mask; // [RULE11]
                        next_cs = next_cs & cs_mask;
                        if (cs_one_low) begin
                            next_ac = addr_cmd_in; // [RULE11]
                        end
                        next_err = ~(cs_one_low & (^addr_cmd_in ^ par_d)); // [RULE11]
                        next_err_oe = cs_one_low & (^addr_cmd_in ^ par_d);
                    end
                end
                default: begin
                    next_state = RRI_RESET;
                end
            endcase
        end
        if (next_yrun) begin
            next_fb_div = ~fb_div;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= RRI_RESET;
            cnt <= '0;
            par_d <= 1'b0;
            fb_div <= 1'b0;
            chip_select_out <= '0;
            chip_select_oe <= '0;
            termination_ctrl_out <= '0;
            termination_ctrl_oe <= 1'b0;
            clock_enable_out <= '0;
            clock_enable_oe <= 1'b1;
            addr_cmd_out <= '0;
            addr_cmd_oe <= 1'b0;
            parity_error_out <= 1'b1;
            parity_error_oe <= 1'b0;
            out_clock_run <= 1'b0;
            out_clock_oe <= 1'b0;
            feedback_clock_out <= 1'b0;
            feedback_clock_oe <= 1'b0;
            init_done <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            par_d <= next_par_d;
            fb_div <= next_fb_div;
            chip_select_out <= next_cs;
            chip_select_oe <= next_cs_oe;
            termination_ctrl_out <= next_odt;
            termination_ctrl_oe <= next_odt_oe;
            clock_enable_out <= next_cke;
            clock_enable_oe <= next_cke_oe;
            addr_cmd_out <= next_ac;
            addr_cmd_oe <= next_ac_oe;
            parity_error_out <= next_err;
            parity_error_oe <= next_err_oe;
            out_clock_run <= next_yrun;
            out_clock_oe <= next_yoe;
            feedback_clock_out <= next_fb_div;
            feedback_clock_oe <= next_fb_oe;
            init_done <= next_done;
        end
    end
endmodule

// File: rri_seq_properties.sv
// Checker for reset and initialization outputs
`timescale 1ns/1ps
module rri_seq_chk
    import rri_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Controls
    input wire logic reset_n,
    input wire logic four_select_mode,
    input wire logic input_clock_rise,
    input wire logic [rri_pkg::ODT_W-1:0] termination_ctrl_in,
    input wire logic [rri_pkg::CKE_W-1:0] clock_enable_in,
    // Outputs
    input wire logic init_done,
    input wire logic [rri_pkg::CS_W-1:0] chip_select_out,
    input wire logic [rri_pkg::CS_W-1:0] chip_select_oe,
    input wire logic [rri_pkg::ODT_W-1:0] termination_ctrl_out,
    input wire logic termination_ctrl_oe,
    input wire logic [rri_pkg::CKE_W-1:0] clock_enable_out,
    input wire logic clock_enable_oe,
    input wire logic addr_cmd_oe,
    input wire logic parity_error_out,
    input wire logic parity_error_oe,
    input wire logic out_clock_run,
    input wire logic out_clock_oe,
    input wire logic feedback_clock_out
);
    import rri_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    cke_low_a: assert property (!reset_n |=> clock_enable_out == 2'h0 && clock_enable_oe)
        else $error("clock enables not low in reset");
    err_idle_a: assert property (!reset_n |=> parity_error_out && !parity_error_oe)
        else $error("parity error not idle in reset");
    float_out_a: assert property (!reset_n |=>
        chip_select_oe == 4'h0 && !termination_ctrl_oe && !addr_cmd_oe && !out_clock_oe)
        else $error("outputs driven in reset");
    odt_low_a: assert property ($rose(reset_n) |=> termination_ctrl_oe && termination_ctrl_out == 2'h0)
        else $error("termination not low after release");
    cs_high_a: assert property ($rose(reset_n) |=>
        (chip_select_out | ~chip_select_oe) == 4'hf && chip_select_oe[1:0] == 2'h3)
        else $error("selects not high after release");
    clk_run_a: assert property ($rose(reset_n) |=> out_clock_run && out_clock_oe)
        else $error("output clocks not restarted");
    cs_width_a: assert property (!four_select_mode |-> chip_select_oe[3:2] == 2'h0)
        else $error("upper selects driven in two-select mode");
    odt_follow_a: assert property (reset_n && termination_ctrl_oe && input_clock_rise |=>
        termination_ctrl_out == $past(termination_ctrl_in))
        else $error("termination not following input");
    cke_follow_a: assert property (init_done && reset_n && input_clock_rise |=>
        clock_enable_out == $past(clock_enable_in))
        else $error("clock enables not following input");
    cke_hold_a: assert property (!init_done |=> clock_enable_out == 2'h0)
        else $error("clock enables raised before stabilization end");
    fb_toggle_a: assert property (out_clock_run && reset_n |=>
        feedback_clock_out != $past(feedback_clock_out))
        else $error("feedback clock not running");
    cover property ($rose(reset_n));
    cover property ($rose(init_done));
    cover property (init_done && input_clock_rise && clock_enable_in != 2'h0);
endmodule
bind rri_seq rri_seq_chk u_chk (.core_clk, .srst, .reset_n, .four_select_mode, .input_clock_rise, .init_done,
    .termination_ctrl_in, .clock_enable_in, .chip_select_out, .chip_select_oe, .termination_ctrl_out,
    .clock_enable_out, .termination_ctrl_oe, .clock_enable_oe, .addr_cmd_oe, .parity_error_out,
    .parity_error_oe, .out_clock_run, .out_clock_oe, .feedback_clock_out);

// File: rri_ctrl_model.sv
// Memory controller model driving reset, selects, clock enables and clock edges
`timescale 1ns/1ps
module rri_ctrl_model (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [2:0] gap,
    input wire logic init_done,
    input wire logic [1:0] cke_req,
    input wire logic [3:0] cs_req,
    output logic reset_n = 1'b0,
    output logic [3:0] chip_select_in = 4'hf,
    output logic [1:0] clock_enable_in = 2'h0,
    output logic input_clock_rise = 1'b0
);
    // Power-up hold of 200 us and soft-reset hold of 100 ns, in core_clk cycles
    localparam int PWR_HOLD_CYC = 8000;
    localparam int SOFT_HOLD_CYC = 4;
    int low_cnt = 0;
    int edge_cnt = 0;
    int hold_cyc = PWR_HOLD_CYC;
    // Everything moves on the clock edge, so the sequencer and the bench see settled values
    always @(posedge core_clk) begin
        edge_cnt = (edge_cnt + 1) % int'(gap);
        low_cnt = reset_n ? 0 : low_cnt + 1;
        if (reset_n) begin
            hold_cyc = SOFT_HOLD_CYC;
        end
        input_clock_rise <= (edge_cnt == 0) && reset_n;
        reset_n <= go && (reset_n || low_cnt >= hold_cyc);
        chip_select_in <= init_done ? cs_req : 4'hf;
        clock_enable_in <= init_done ? cke_req : 2'h0;
    end
endmodule

// File: tb_top.sv
// Self-checking testbench for the reset and initialization sequencer
`timescale 1ns/1ps
module tb_top;
    import rri_pkg::*;
    logic core_clk = 0, srst = 1, go = 0, mode = 0, par = 0, reset_n, rise, init_done, odt_oe, cke_oe, err, err_oe;
    logic [2:0] gap = 1;
    logic [1:0] odt = 0, cke_req = 0, cke_in, odt_out, cke_out, prev;
    logic [3:0] cs_req = 4'hf, cs_in, cs_out, cs_oe, exp_cs;
    logic [23:0] ac = 0, ac_out, exp_ac;
    logic [1:0] exp_cke;
    logic ac_oe, clk_run, clk_oe, fb, fb_oe, fb_prev;
    int fail_count = 0, compares = 0, cycles = 0, n, seed = 32'h22dc;
    always #12.5 core_clk = ~core_clk;
    rri_ctrl_model u_ctrl (.core_clk, .go, .gap, .init_done, .cke_req, .cs_req, .reset_n,
        .chip_select_in(cs_in), .clock_enable_in(cke_in), .input_clock_rise(rise));
    rri_seq u_dut (.core_clk, .srst, .reset_n, .four_select_mode(mode), .chip_select_in(cs_in),
        .termination_ctrl_in(odt), .clock_enable_in(cke_in), .addr_cmd_in(ac), .parity_in(par),
        .input_clock_rise(rise), .chip_select_out(cs_out), .chip_select_oe(cs_oe),
        .termination_ctrl_out(odt_out), .termination_ctrl_oe(odt_oe), .clock_enable_out(cke_out),
        .clock_enable_oe(cke_oe), .addr_cmd_out(ac_out), .addr_cmd_oe(ac_oe), .parity_error_out(err),
        .parity_error_oe(err_oe), .out_clock_run(clk_run), .out_clock_oe(clk_oe), .feedback_clock_out(fb),
        .feedback_clock_oe(fb_oe), .init_done);
    task chk(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [3:0] cs_mask_of(logic m);
        return m ? 4'hf : 4'h3;
    endfunction
    function automatic logic one_low(logic [3:0] cs, logic m);
        return $countones(~cs & cs_mask_of(m)) == 1;
    endfunction
    task tick(int k);
        repeat (k) @(posedge core_clk);
        #2;
    endtask
    task wrap_up;
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        for (int p = 0; p < 4; p++) begin
            srst = 1;
            go = 0;
            mode = p[0];
            gap = p[1] ? 3'h3 : 3'h1;
            tick(5);
            srst = 0;
            tick(3);
            chk("reset_state", {cke_out, err, err_oe, cs_oe, odt_oe}, {2'h0, 1'b1, 1'b0, 4'h0, 1'b0});
            chk("reset_float", {ac_oe, clk_oe, fb_oe}, 3'h0);
            go = 1;
            n = 0;
            while (!reset_n && n < 10000) begin
                tick(1);
                n++;
            end
            tick(1);
            chk("release_cs_oe", cs_oe, cs_mask_of(mode));
            chk("release_cs", cs_out, cs_mask_of(mode));
            chk("release_odt", {odt_oe, odt_out}, 3'h4);
            chk("release_drive", {ac_oe, ac_out, clk_run, clk_oe, fb_oe}, {1'b1, 24'h0, 3'h7});
            n = 0;
            while (!rise && n < 20) begin
                tick(1);
                n++;
            end
            n = 0;
            while (!init_done && n < 2000) begin
                tick(1);
                n++;
            end
            chk("stab_cycles", n, STAB_CYC + 1);
            prev = odt;
            exp_cs = cs_mask_of(mode);
            exp_cke = 2'h0;
            exp_ac = 24'h0;
            repeat (40) begin
                odt = 2'($random(seed));
                cke_req = 2'($random(seed));
                cs_req = 4'($random(seed));
                ac = 24'($random(seed));
                par = 1'($random(seed));
                // Termination, clock-enable, select and address outputs move only on the edge that samples a rise pulse
                if (rise) begin
                    prev = odt;
                    exp_cke = cke_in;
                    exp_cs = cs_in & cs_mask_of(mode);
                    if (one_low(cs_in, mode)) begin
                        exp_ac = ac;
                    end
                end
                fb_prev = fb;
                tick(1);
                chk("odt_follow", odt_out, prev);
                chk("cke_follow", cke_out, exp_cke);
                chk("cs_follow", cs_out, exp_cs);
                chk("ac_follow", ac_out, exp_ac);
                chk("err_drain", err_oe, !err);
                chk("fb_toggle", fb, !fb_prev);
            end
            go = 0;
            tick(3);
            chk("soft_reset", {cke_out, cs_oe, err}, {2'h0, 4'h0, 1'b1});
            chk("soft_float", {ac_oe, clk_oe, odt_oe, fb_oe}, 4'h0);
        end
        wrap_up();
    end
endmodule
